// >>> inc/dmac_defs.svh
// dual mac constants: register offsets, status bits, bounds
// assumes inclusion by bare name from the core logic
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH
// ==========================================
// register offsets (word index on the port)
`define DMAC_A_STATUS   3'h0
`define DMAC_A_ACC0_W   3'h1
`define DMAC_A_ACC0_X   3'h2
`define DMAC_A_ACC1_W   3'h3
`define DMAC_A_ACC1_X   3'h4
// ==========================================
// status word bit positions
`define DMAC_ST_AV0     16
`define DMAC_ST_ACC0_OVF_STICKY    17
`define DMAC_ST_AV1     18
`define DMAC_ST_ACC1_OVF_STICKY    19
`define DMAC_ST_V       24
`define DMAC_ST_VS      25
`define DMAC_ST_MASK    32'h030F_0000
// ==========================================
// reset values
`define DMAC_STATUS_RST 32'h0000_0000
`define DMAC_ACC_RST    40'h00_0000_0000
// ==========================================
// rounding and saturation bounds
`define DMAC_RND_HALF   42'sh000_0000_8000
`define DMAC_SMAX16     42'sh000_0000_7FFF
`define DMAC_SMIN16     42'sh3FF_FFFF_8000
`define DMAC_UMAX16     42'sh000_0000_FFFF
`define DMAC_SMAX32     42'sh000_7FFF_FFFF
`define DMAC_SMIN32     42'sh3FF_8000_0000
`define DMAC_UMAX32     42'sh000_FFFF_FFFF
`define DMAC_SMAX40     42'sh07F_FFFF_FFFF
`define DMAC_SMIN40     42'sh380_0000_0000
`define DMAC_ZERO42     42'sh000_0000_0000
`endif

// >>> inc/dmac_pkg.sv
// dual mac types: formats, accumulate ops, destinations, carriers
// assumes dmac_defs.svh sits beside it
package dmac_pkg;
   // ==========================================
   // operand format options
   typedef enum logic [3:0] {
      FMT_SFRAC,               // default signed fraction
      FMT_SIGNED_INT,
      FMT_UNSIGNED_FRAC,
      FMT_UNSIGNED_INT,
      FMT_SFRAC_CHOP,          // signed fraction, truncating
      FMT_UNSIGNED_FRAC_CHOP,
      FMT_INT_SCALED_X2,
      FMT_INT_HIGH_ROUND,
      FMT_LEGACY_32BIT_ACC
   } dmac_fmt_t;
   // accumulator action
   typedef enum logic [1:0] {ACC_NONE, ACC_LOAD, ACC_ADD, ACC_SUB} dmac_acc_t;
   // data register destination
   typedef enum logic [1:0] {DST_NONE, DST_HALF, DST_FULL} dmac_dst_t;
   // ==========================================
   // one unit's slice of an instruction
   typedef struct packed {
      dmac_acc_t accOp;
      dmac_dst_t dest;
      dmac_fmt_t fmt;
      logic      mixed;        // signed x unsigned, high unit only
      logic      selA;         // 1: high half of first word
      logic      selB;         // 1: high half of second word
   } dmac_unit_op_t;
   // instruction issued from decode
   typedef struct packed {
      logic          valid;
      dmac_unit_op_t lo;
      dmac_unit_op_t hi;
   } dmac_issue_t;
   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  addr;
      logic [31:0] wdata;
   } dmac_bus_req_t;
endpackage

// >>> logic/dmac_core.sv
// dual 16x16 multiply-accumulate datapath with two 40-bit accumulators
// assumes decode issues at most one instruction a cycle and the register
// file takes results one cycle after issue
`include "dmac_defs.svh"

// How it works
// - accumulator load sign-extends product into top byte, zero-fills for unsigned formats
// - rounding only for fractions, plus high-round option
// - high-round adds 0x8000, then saturates to 32
// - extraction overflow loads largest value of true sign
// - bits 16/18 flag accumulator beyond 32 bits
// - sticky accumulator flags survive later clean operations
// - extraction overflow sets bits 24 and 25
// - register-only multiplies touch extraction flags only
// - accumulator-only multiplies touch accumulator flags only
// - accumulate with extraction updates both flag groups
// - default signed fraction; signed chop and legacy shift too, other formats skip shift
// - chop options drop low sixteen bits unrounded
// - scaled option doubles, saturates full word to 32 bits
// - scaled option doubles, saturates half to 16
// - high-round saturates, rounds bits 31:16 into half
// - legacy option: 32-bit accumulator, 0x8000 squared
// - mixed mode only on high unit
// - each operand picks a half of one word
// - product adds, subtracts, or passes through 40-bit adder
// - accumulator reachable as word and extension byte
// - low half from low unit, high from high
// - half extract: high for fractions and high-round, low for other integers
// - signed fractions get one-bit left shift
// - accumulator fields 15:0, 31:16, 39:32
module dmac_core (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire dmac_pkg::dmac_issue_t   issue,
   input  wire logic [31:0]             wordA,
   input  wire logic [31:0]             wordB,
   input  wire dmac_pkg::dmac_bus_req_t busReq,
   output      logic [31:0]             busRdata_q,
   output      logic [31:0]             dregLo_q,
   output      logic [1:0]              dregLoWe_q,
   output      logic [31:0]             dregHi_q,
   output      logic [1:0]              dregHiWe_q,
   output      logic [31:0]             arithStatusWord_q
);
   // ==========================================
   // arithmetic helpers

   // saturate to 32 or 16 bits, signed or unsigned; msb flags a clip
   function automatic logic [32:0] satVal(
      input logic signed [41:0] v,
      input logic               uns,
      input logic               half);
      logic signed [41:0] hiB;
      logic signed [41:0] loB;
      hiB = uns ? (half ? `DMAC_UMAX16 : `DMAC_UMAX32)
                : (half ? `DMAC_SMAX16 : `DMAC_SMAX32);
      loB = uns ? `DMAC_ZERO42 : (half ? `DMAC_SMIN16 : `DMAC_SMIN32);
      if (v > hiB) begin
         return {1'b1, hiB[31:0]};
      end
      if (v < loB) begin
         return {1'b1, loB[31:0]};
      end
      return {1'b0, v[31:0]};
   endfunction

   // unsigned operand formats
   function automatic logic isUns(input dmac_pkg::dmac_fmt_t f);
      return f == dmac_pkg::FMT_UNSIGNED_FRAC || f == dmac_pkg::FMT_UNSIGNED_INT ||
             f == dmac_pkg::FMT_UNSIGNED_FRAC_CHOP;
   endfunction

   // 16x16 product, widened to 40 bits
   function automatic logic [39:0] mulProd(
      input logic [15:0]          a,
      input logic [15:0]          b,
      input dmac_pkg::dmac_fmt_t  f,
      input logic                 mixed);
      logic               sa;
      logic               sb;
      logic               shl;
      logic signed [17:0] ea;
      logic signed [17:0] eb;
      logic signed [35:0] p;
      logic [31:0]        p32;
      sa  = !isUns(f) || mixed;           // first operand signed
      sb  = !isUns(f) && !mixed;          // second unsigned in mixed
      // only signed-fraction formats drop the duplicate sign bit
      shl = !mixed && (f == dmac_pkg::FMT_SFRAC || f == dmac_pkg::FMT_SFRAC_CHOP ||
                       f == dmac_pkg::FMT_LEGACY_32BIT_ACC);
      ea  = {{2{sa & a[15]}}, a};
      eb  = {{2{sb & b[15]}}, b};
      p   = ea * eb;
      if (shl) begin
         p = p <<< 1;
      end
      // the one product that cannot fit: min times min
      if (p > 36'sh0_7FFF_FFFF && !(sa == 1'b0 && sb == 1'b0)) begin
         p32 = 32'(`DMAC_SMAX32);
      end else begin
         p32 = p[31:0];
      end
      if (!sa && !sb) begin
         return {8'h00, p32};             // unsigned stays positive
      end
      return {{8{p32[31]}}, p32};          // sign fill top byte
   endfunction

   // move a 40-bit value into a data register; msb flags a clip
   function automatic logic [32:0] extract(
      input logic [39:0]         v,
      input dmac_pkg::dmac_fmt_t f,
      input logic                half);
      logic signed [41:0] sv;
      logic [32:0]        t;
      logic [32:0]        r;
      logic               chop;
      sv   = {{2{v[39]}}, v};
      chop = f == dmac_pkg::FMT_SFRAC_CHOP || f == dmac_pkg::FMT_UNSIGNED_FRAC_CHOP;
      case (f)
         dmac_pkg::FMT_INT_SCALED_X2: begin
            // doubling first, then clip to the destination width
            return satVal(sv <<< 1, 1'b0, half);
         end
         dmac_pkg::FMT_SIGNED_INT, dmac_pkg::FMT_UNSIGNED_INT: begin
            // integers keep the low half on a half write
            return satVal(sv, isUns(f), half);
         end
         dmac_pkg::FMT_INT_HIGH_ROUND: begin
            if (!half) begin
               return satVal(sv, 1'b0, 1'b0);
            end
            t = satVal(sv, 1'b0, 1'b0);
            r = satVal({{10{t[31]}}, t[31:0]} + `DMAC_RND_HALF, 1'b0, 1'b0);
            return {t[32] | r[32], 16'h0000, r[31:16]};
         end
         default: begin
            if (!half) begin
               return satVal(sv, isUns(f), 1'b0);
            end
            // fractions keep the high half, rounded unless chopped
            r = satVal(chop ? sv : sv + `DMAC_RND_HALF, isUns(f), 1'b0);
            return {r[32], 16'h0000, r[31:16]};
         end
      endcase
   endfunction

   // ==========================================
   // state

   logic [1:0][39:0] acc_q;     // accumulators, index 0 and 1
   logic [1:0][39:0] acc_d;
   logic [1:0]       accOvf;    // new value spills past 32 bits
   logic [1:0]       spill;     // extraction clipped
   logic [1:0]       accUse;    // unit writes its accumulator
   logic [1:0]       dstUse;    // unit writes a data register
   logic [1:0][31:0] resVal;
   logic [1:0]       spill_q;   // last cycle's clip per unit
   logic [31:0]      status_d;
   logic             stWr;      // status word written this cycle

   assign stWr = busReq.wr && busReq.addr == `DMAC_A_STATUS;

   // ==========================================
   // per-unit datapath
   always_comb begin
      dmac_pkg::dmac_unit_op_t op;
      logic [15:0]        a;
      logic [15:0]        b;
      logic [39:0]        prod;
      logic signed [41:0] sum;
      logic [32:0]        sat;
      logic [39:0]        newAcc;
      logic [32:0]        ex;
      op = '0;
      a = '0;
      b = '0;
      prod = '0;
      sum = '0;
      sat = '0;
      newAcc = '0;
      ex = '0;
      for (int u = 0; u < 2; u++) begin
         op = (u == 1) ? issue.hi : issue.lo;
         if (u == 0) begin
            op.mixed = 1'b0;                    // low unit never mixes
         end
         a = op.selA ? wordA[31:16] : wordA[15:0];
         b = op.selB ? wordB[31:16] : wordB[15:0];
         prod = mulProd(a, b, op.fmt, op.mixed);
         // 40-bit add/subtract stage, two guard bits
         case (op.accOp)
            dmac_pkg::ACC_ADD: sum = {{2{acc_q[u][39]}}, acc_q[u]} + {{2{prod[39]}}, prod};
            dmac_pkg::ACC_SUB: sum = {{2{acc_q[u][39]}}, acc_q[u]} - {{2{prod[39]}}, prod};
            default:           sum = {{2{prod[39]}}, prod};
         endcase
         accOvf[u] = sum > `DMAC_SMAX32 || sum < `DMAC_SMIN32;
         if (op.fmt == dmac_pkg::FMT_LEGACY_32BIT_ACC) begin
            // no extension bits: the word itself saturates
            sat = satVal(sum, 1'b0, 1'b0);
            newAcc = {{8{sat[31]}}, sat[31:0]};
         end else if (sum > `DMAC_SMAX40) begin
            newAcc = 40'(`DMAC_SMAX40);
         end else if (sum < `DMAC_SMIN40) begin
            newAcc = 40'(`DMAC_SMIN40);
         end else begin
            newAcc = sum[39:0];
         end
         accUse[u] = issue.valid && op.accOp != dmac_pkg::ACC_NONE;
         dstUse[u] = issue.valid && op.dest != dmac_pkg::DST_NONE;
         // with no accumulation the product goes straight out
         ex = extract(accUse[u] ? newAcc : prod, op.fmt, op.dest == dmac_pkg::DST_HALF);
         spill[u] = dstUse[u] && ex[32];
         resVal[u] = ex[31:0];
         acc_d[u] = accUse[u] ? newAcc : acc_q[u];
      end
   end

   // ==========================================
   // accumulators: instruction wins over a port write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= {`DMAC_ACC_RST, `DMAC_ACC_RST};
      end else begin
         acc_q <= acc_d;
         // word and extension byte are written apart
         if (busReq.wr && !accUse[0] && busReq.addr == `DMAC_A_ACC0_W) begin
            acc_q[0][31:0] <= busReq.wdata;
         end
         if (busReq.wr && !accUse[0] && busReq.addr == `DMAC_A_ACC0_X) begin
            acc_q[0][39:32] <= busReq.wdata[7:0];
         end
         if (busReq.wr && !accUse[1] && busReq.addr == `DMAC_A_ACC1_W) begin
            acc_q[1][31:0] <= busReq.wdata;
         end
         if (busReq.wr && !accUse[1] && busReq.addr == `DMAC_A_ACC1_X) begin
            acc_q[1][39:32] <= busReq.wdata[7:0];
         end
      end
   end

   // ==========================================
   // data register results, one cycle after issue
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dregLo_q   <= 32'h0000_0000;
         dregHi_q   <= 32'h0000_0000;
         dregLoWe_q <= 2'b00;
         dregHiWe_q <= 2'b00;
         spill_q    <= 2'b00;
      end else begin
         spill_q <= spill;
         // low unit fills the low half lane, high unit the high
         dregLo_q   <= resVal[0];
         dregLoWe_q <= !dstUse[0] ? 2'b00 :
                       (issue.lo.dest == dmac_pkg::DST_HALF) ? 2'b01 : 2'b11;
         dregHi_q   <= (issue.hi.dest == dmac_pkg::DST_HALF) ?
                       {resVal[1][15:0], 16'h0000} : resVal[1];
         dregHiWe_q <= !dstUse[1] ? 2'b00 :
                       (issue.hi.dest == dmac_pkg::DST_HALF) ? 2'b10 : 2'b11;
      end
   end

   // ==========================================
   // status word: software write first, hardware events on top
   always_comb begin
      status_d = arithStatusWord_q;
      if (stWr) begin
         status_d = busReq.wdata & `DMAC_ST_MASK;
      end
      if (accUse[0]) begin
         status_d[`DMAC_ST_AV0] = accOvf[0];
         status_d[`DMAC_ST_ACC0_OVF_STICKY] = status_d[`DMAC_ST_ACC0_OVF_STICKY] | accOvf[0];
      end
      if (accUse[1]) begin
         status_d[`DMAC_ST_AV1] = accOvf[1];
         status_d[`DMAC_ST_ACC1_OVF_STICKY] = status_d[`DMAC_ST_ACC1_OVF_STICKY] | accOvf[1];
      end
      if (|dstUse) begin
         status_d[`DMAC_ST_V] = |spill;
         status_d[`DMAC_ST_VS] = status_d[`DMAC_ST_VS] | (|spill);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arithStatusWord_q <= `DMAC_STATUS_RST;
      end else begin
         arithStatusWord_q <= status_d;
      end
   end

   // ==========================================
   // register port read: data valid the cycle after, zero otherwise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busRdata_q <= 32'h0000_0000;
      end else if (!busReq.rd) begin
         busRdata_q <= 32'h0000_0000;
      end else begin
         case (busReq.addr)
            `DMAC_A_STATUS: busRdata_q <= arithStatusWord_q;
            `DMAC_A_ACC0_W: busRdata_q <= acc_q[0][31:0];
            `DMAC_A_ACC0_X: busRdata_q <= {24'h00_0000, acc_q[0][39:32]};
            `DMAC_A_ACC1_W: busRdata_q <= acc_q[1][31:0];
            `DMAC_A_ACC1_X: busRdata_q <= {24'h00_0000, acc_q[1][39:32]};
            default:        busRdata_q <= 32'h0000_0000; // unmapped
         endcase
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence loLoad;
      issue.valid && issue.lo.accOp == dmac_pkg::ACC_LOAD;
   endsequence
   sequence loAccPlain;
      accUse[0] && issue.lo.fmt != dmac_pkg::FMT_LEGACY_32BIT_ACC;
   endsequence
   sequence stickyHeld;
      arithStatusWord_q[`DMAC_ST_ACC0_OVF_STICKY] && !stWr;
   endsequence
   sequence stickyCleared;
      stWr && !busReq.wdata[`DMAC_ST_ACC0_OVF_STICKY] && !accUse[0];
   endsequence

   ext_sign_a: assert property (loLoad |=> acc_q[0][39:32] == {8{acc_q[0][31]}})
      else $error("extension byte is not sign fill");
   ovf_bit_a: assert property (loAccPlain |=>
      arithStatusWord_q[`DMAC_ST_AV0] == (acc_q[0][39:31] != {9{acc_q[0][39]}}))
      else $error("overflow bit disagrees with accumulator");
   sticky_hold_a: assert property (stickyHeld |=> arithStatusWord_q[`DMAC_ST_ACC0_OVF_STICKY])
      else $error("sticky bit dropped without a write");
   spill_flag_a: assert property (|spill_q |->
      arithStatusWord_q[`DMAC_ST_V] && arithStatusWord_q[`DMAC_ST_VS])
      else $error("clip did not raise both flags");
   dst_only_a: assert property (issue.valid && accUse == 2'b00 && !stWr |=>
      $stable(arithStatusWord_q[`DMAC_ST_AV0]) && $stable(arithStatusWord_q[`DMAC_ST_AV1]))
      else $error("register-only op moved accumulator flag");
   acc_only_a: assert property (issue.valid && dstUse == 2'b00 && !stWr |=>
      $stable(arithStatusWord_q[`DMAC_ST_V]) && dregLoWe_q == 2'b00 && dregHiWe_q == 2'b00)
      else $error("accumulator-only op touched extraction");
   both_upd_a: assert property (accUse[0] && dstUse[0] |=>
      arithStatusWord_q[`DMAC_ST_V] == (|spill_q) &&
      (!arithStatusWord_q[`DMAC_ST_AV0] || arithStatusWord_q[`DMAC_ST_ACC0_OVF_STICKY]))
      else $error("combined op missed a flag group");
   sat_value_a: assert property (dregLoWe_q == 2'b11 && spill_q[0] |->
      dregLo_q inside {32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0000})
      else $error("clipped word is not an extreme");
   lane_route_a: assert property (dregLoWe_q != 2'b10 && dregHiWe_q != 2'b01)
      else $error("unit wrote the wrong half");
   sticky_clr_a: assert property (stickyCleared |=> !arithStatusWord_q[`DMAC_ST_ACC0_OVF_STICKY])
      else $error("sticky bit not cleared by write");
endmodule

// >>> sim/dmac_dreg_model.sv
// data register file image fed by the two multiplier units
// assumes lane enables pulse for one cycle beside their result word
module dmac_dreg_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [31:0] dregLo,
   input  wire logic [1:0]  loWe,
   input  wire logic [31:0] dregHi,
   input  wire logic [1:0]  hiWe,
   output      logic [31:0] regLo,
   output      logic [31:0] regHi
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // lane capture
   // each unit owns its own destination, so a dual full write never collides
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regLo <= 32'h0000_0000;
         regHi <= 32'h0000_0000;
      end else begin
         for (int l = 0; l < 2; l++) begin
            // only enabled lanes change, the other half keeps its old contents
            if (loWe[l]) regLo[16*l +: 16] <= dregLo[16*l +: 16];
            if (hiWe[l]) regHi[16*l +: 16] <= dregHi[16*l +: 16];
         end
      end
   end
endmodule

// >>> sim/tb_dual_mac_multiplier.sv
// self-checking bench for the dual multiply-accumulate datapath
// assumes dmac_pkg, dmac_core and the register image model compile first
module tb_dual_mac_multiplier;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // stimulus and observation
   logic                    clk;
   logic                    arst_n;
   dmac_pkg::dmac_issue_t   issue;
   logic [31:0]             wordA;
   logic [31:0]             wordB;
   dmac_pkg::dmac_bus_req_t busReq;
   logic [31:0]             busRdata, dregLo, dregHi, status, regLo, regHi;
   logic [1:0]              loWe, hiWe;
   logic [31:0]             rv;           // last read value
   logic [1:0]              wl, wh;       // lane enables seen after an issue
   dmac_pkg::dmac_unit_op_t nop;          // unit left idle
   dmac_pkg::dmac_acc_t     ao;           // accumulate step of the overflow run
   int                      failures, samplesChecked;
   int unsigned             prod [4] = '{32'd21, 32'd15, 32'd14, 32'd10};
   // ==========================================
   // device and far side
   dmac_core u_dmac_core (.clk(clk), .arst_n(arst_n), .issue(issue), .wordA(wordA), .wordB(wordB),
      .busReq(busReq), .busRdata_q(busRdata), .dregLo_q(dregLo), .dregLoWe_q(loWe), .dregHi_q(dregHi),
      .dregHiWe_q(hiWe), .arithStatusWord_q(status));
   dmac_dreg_model u_dmac_dreg_model (.clk(clk), .arst_n(arst_n), .dregLo(dregLo), .loWe(loWe),
      .dregHi(dregHi), .hiWe(hiWe), .regLo(regLo), .regHi(regHi));
   always #5 clk = ~clk;
   // ==========================================
   // compares, one per kind of result
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkLanes(input logic [1:0] got, input logic [1:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: lanes %h expected %h", $time, got, exp);
      end
   endtask
   // ==========================================
   // register port: one-cycle strobes, read data in the following cycle only
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      busReq <= '0;
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      busReq <= '0;
      #1 rv = busRdata;
      chkWord(rv & m, exp);
   endtask
   // ==========================================
   // instruction issue: results and lane pulses stand one cycle after issue
   function automatic dmac_pkg::dmac_unit_op_t u(input dmac_pkg::dmac_acc_t ac, input dmac_pkg::dmac_dst_t ds,
      input dmac_pkg::dmac_fmt_t f, input logic m = 1'b0, input logic sa = 1'b0, input logic sb = 1'b0);
      u = '{accOp: ac, dest: ds, fmt: f, mixed: m, selA: sa, selB: sb};
   endfunction
   task automatic mac(input dmac_pkg::dmac_unit_op_t lo, hi, input logic [31:0] a, b);
      @(posedge clk);
      issue <= '{valid: 1'b1, lo: lo, hi: hi};
      wordA <= a;
      wordB <= b;
      @(posedge clk);
      issue <= '0;
      #1 wl = loWe;
      wh = hiWe;
      // one more edge lets the register image take the lanes
      @(posedge clk);
      #1;
   endtask
   // checks the enabled lanes of one unit's destination only
   task automatic run(input dmac_pkg::dmac_unit_op_t lo, hi, input logic [31:0] a, b, input logic useHi,
      input logic [1:0] el, input logic [31:0] ev);
      mac(lo, hi, a, b);
      chkLanes(useHi ? wh : wl, el);
      chkWord((useHi ? regHi : regLo) & {{16{el[1]}}, {16{el[0]}}}, ev);
   endtask
   // ==========================================
   // verdict and watchdog
   task automatic stop_test;
      if (failures == 0 && samplesChecked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test;
   end
   // ==========================================
   // main sequence
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      issue = '0;
      wordA = 32'h0000_0000;
      wordB = 32'h0000_0000;
      busReq = '0;
      failures = 0;
      samplesChecked = 0;
      nop = u(dmac_pkg::ACC_NONE, dmac_pkg::DST_NONE, dmac_pkg::FMT_SFRAC);
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rdChk(3'h0, 32'h0000_0000);
      // signed fraction load gets the one-bit correction, negative fills the top byte
      mac(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SFRAC), nop, 32'h0000_4000, 32'h0000_4000);
      rdChk(3'h1, 32'h2000_0000);
      mac(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SFRAC), nop, 32'h0000_C000, 32'h0000_4000);
      rdChk(3'h1, 32'hE000_0000);
      rdChk(3'h2, 32'h0000_00FF, 32'h0000_00FF);
      // all four half pairings, integer so no shift
      for (int k = 0; k < 4; k++) begin
         mac(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT, 1'b0, k[1], k[0]), nop,
            32'h0002_0003, 32'h0005_0007);
         rdChk(3'h1, prod[k]);
      end
      // add then subtract the same product
      mac(u(dmac_pkg::ACC_ADD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT), nop, 32'h0000_0003, 32'h0000_0007);
      rdChk(3'h1, 32'h0000_001F);
      mac(u(dmac_pkg::ACC_SUB, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT), nop, 32'h0000_0003, 32'h0000_0007);
      rdChk(3'h1, 32'h0000_000A);
      // register-only multiply: integer low half clips, accumulator flags untouched
      wr(3'h0, 32'h000F_0000);
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_SIGNED_INT), nop, 32'h0000_0100, 32'h0000_0100,
         1'b0, 2'h1, 32'h0000_7FFF);
      rdChk(3'h0, 32'h030F_0000);
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_SFRAC), nop, 32'h0000_4000, 32'h0000_4000,
         1'b0, 2'h1, 32'h0000_2000);
      rdChk(3'h0, 32'h020F_0000);
      // round against chop on the lowest kept bit
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_SFRAC), nop, 32'h0000_4000, 32'h0000_0001,
         1'b0, 2'h1, 32'h0000_0001);
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_SFRAC_CHOP), nop, 32'h0000_4000, 32'h0000_0001,
         1'b0, 2'h1, 32'h0000_0000);
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_UNSIGNED_FRAC), nop, 32'h0000_8000,
         32'h0000_0001, 1'b0, 2'h1, 32'h0000_0001);
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_UNSIGNED_FRAC_CHOP), nop, 32'h0000_8000,
         32'h0000_0001, 1'b0, 2'h1, 32'h0000_0000);
      // high unit halves: unsigned integer clip and integer high round
      run(nop, u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_UNSIGNED_INT), 32'h0000_FFFF,
         32'h0000_0002, 1'b1, 2'h2, 32'hFFFF_0000);
      run(nop, u(dmac_pkg::ACC_NONE, dmac_pkg::DST_HALF, dmac_pkg::FMT_INT_HIGH_ROUND), 32'h0000_0100,
         32'h0000_0180, 1'b1, 2'h2, 32'h0002_0000);
      // scaled integer, full and half, with accumulation: both flag groups move
      wr(3'h0, 32'h0001_0000);
      run(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_FULL, dmac_pkg::FMT_INT_SCALED_X2), nop, 32'h0000_8000,
         32'h0000_8000, 1'b0, 2'h3, 32'h7FFF_FFFF);
      rdChk(3'h0, 32'h0300_0000);
      run(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_HALF, dmac_pkg::FMT_INT_SCALED_X2), nop, 32'h0000_0100,
         32'h0000_0080, 1'b0, 2'h1, 32'h0000_7FFF);
      // mixed mode on the high unit only; the low unit stays signed fraction
      run(u(dmac_pkg::ACC_NONE, dmac_pkg::DST_FULL, dmac_pkg::FMT_SFRAC, 1'b1),
         u(dmac_pkg::ACC_NONE, dmac_pkg::DST_FULL, dmac_pkg::FMT_SFRAC, 1'b1), 32'h0000_FFFF, 32'h0000_FFFF,
         1'b1, 2'h3, 32'hFFFF_0001);
      chkWord(regLo, 32'h0000_0002);
      // legacy accumulator: the one special product, no extension bits
      mac(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_LEGACY_32BIT_ACC), nop, 32'h0000_8000,
         32'h0000_8000);
      rdChk(3'h1, 32'h7FFF_FFFF);
      rdChk(3'h2, 32'h0000_0000, 32'h0000_00FF);
      // both accumulators run past 32 bits, then a clean load keeps sticky only
      wr(3'h0, 32'h0300_0000);
      for (int k = 0; k < 3; k++) begin
         ao = dmac_pkg::dmac_acc_t'((k == 0) ? dmac_pkg::ACC_LOAD : dmac_pkg::ACC_ADD);
         mac(u(ao, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT), u(ao, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT),
            32'h0000_7FFF, 32'h0000_7FFF);
      end
      rdChk(3'h0, 32'h030F_0000);
      mac(u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT),
         u(dmac_pkg::ACC_LOAD, dmac_pkg::DST_NONE, dmac_pkg::FMT_SIGNED_INT), 32'h0000_0001, 32'h0000_0001);
      rdChk(3'h0, 32'h030A_0000);
      chkWord(status, 32'h030A_0000);
      wr(3'h0, 32'h0000_0000);
      rdChk(3'h0, 32'h0000_0000);
      // accumulator parts by register, unmapped place, read data lasts one cycle
      wr(3'h3, 32'h1234_5678);
      wr(3'h4, 32'h0000_00A5);
      rdChk(3'h3, 32'h1234_5678);
      rdChk(3'h4, 32'h0000_00A5, 32'h0000_00FF);
      // nonzero read data must be gone one cycle later
      @(posedge clk);
      #1 chkWord(busRdata, 32'h0000_0000);
      rdChk(3'h7, 32'h0000_0000);
      stop_test;
   end
endmodule
